// File: logic/ssp_pkg.sv
// Constants, types and helpers for the synchronous serial shift port
package ssp_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_PORTCFG = 8'h04;
  localparam logic [7:0] ADDR_BUSY = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  // Field positions
  localparam int CTRL_SELECT_BIT = 0;
  localparam int CTRL_RATE_LOW_BIT = 1;
  localparam int CTRL_RATE_HIGH_BIT = 2;
  localparam int CFG_OUT_BIT = 4;
  localparam int CFG_CLK_BIT = 5;
  localparam int CFG_PHASE_BIT = 6;
  localparam int BUSY_BIT = 0;
  localparam int DONE_BIT = 0;
  // Reset values
  localparam logic [1:0] RATE_RESET = 2'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  // Shift geometry
  localparam int DATA_W = 8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  // Timing: instruction cycle and rate encodings
  localparam int CLK_NS = 4;
  localparam int TC_NS = 16;
  localparam int TC_CYCLES = (TC_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] HALF_2TC = 8'(TC_CYCLES);
  localparam logic [7:0] HALF_4TC = 8'(2 * TC_CYCLES);
  localparam logic [7:0] HALF_8TC = 8'(4 * TC_CYCLES);
  localparam logic [7:0] DIV_ONE = 8'h01;
  localparam logic [7:0] DIV_ZERO = 8'h00;
  localparam logic [1:0] RATE_2TC = 2'h0;
  localparam logic [1:0] RATE_4TC = 2'h1;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ssp_apb_req_type;

  typedef struct packed {
    logic shiftClock;
    logic serialIn;
  } ssp_link_in_type;

  typedef struct packed {
    logic shiftClock;
    logic shiftClockOe;
    logic serialOut;
    logic serialOutOe;
  } ssp_link_out_type;

  typedef enum {SH_IDLE, SH_ACTIVE} ssp_state_type;

  // Half period of the generated clock, in ref_clk cycles
  function automatic logic [7:0] sspHalfPeriod(input logic [1:0] rate);
    if (rate == RATE_2TC) begin
      return HALF_2TC;
    end else if (rate == RATE_4TC) begin
      return HALF_4TC;
    end
    return HALF_8TC;
  endfunction
endpackage

// File: logic/ssp_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module ssp_sync #(
  parameter int WIDTH = 2
) (
  input wire logic ref_clk,  // Core clock
  input wire logic reset,  // Sync reset, high
  input wire logic [WIDTH-1:0] asyncIn,  // Pin levels
  output logic [WIDTH-1:0] syncOut  // Synchronised levels
);
  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end

  assign syncOut = stage2_q;
endmodule

// File: logic/ssp_shift_port.sv
// Synchronous serial shift port with APB registers
// Operation
// - Eight-bit shift register with serial in, serial out and shift clock.
// - Internal clock makes it master; external clock makes it slave.
// - Port works only while the select bit is one.
// - Master clock period is 2, 4 or 8 instruction cycles by rate bits.
// - Writing busy one starts shifting; hardware clears it after eight bits.
// - Software clearing busy stops shifting early.
// - Completion of eight bits raises an enabled interrupt.
// - Shift clock idles low when not shifting, both phases.
// - Master generates the clock and initiates every exchange.
// - Out config drives or floats serial out; clock config picks source.
// - Normal phase: sample on rising edge, shift on falling edge.
// - Alternate phase: shift register advances on rising edge.
// - Phase select sits in port G bit 6 configuration position.
// - Phase select is cleared by reset.
`timescale 1ns/1ns
module ssp_shift_port (
  input wire logic ref_clk,  // Core clock
  input wire logic reset,  // Sync reset, high
  input ssp_pkg::ssp_apb_req_type apbReq,  // APB request
  output logic [31:0] prdata,  // APB read data
  output logic pready,  // APB ready
  output logic pslverr,  // APB error
  input ssp_pkg::ssp_link_in_type linkIn,  // Pin inputs
  output ssp_pkg::ssp_link_out_type linkOut,  // Pin outputs and enables
  output logic irq  // Level interrupt
);
  import ssp_pkg::*;

  logic selectQ;
  logic [1:0] rateQ;
  logic outCfgQ;
  logic clkCfgQ;
  logic phaseQ;
  logic busyQ;
  logic [DATA_W-1:0] shiftQ;
  logic sampleQ;
  logic [3:0] bitCntQ;
  logic [7:0] divCntQ;
  logic sckQ;
  logic sckPrevQ;
  logic statusQ;
  logic maskQ;
  logic [31:0] prdataQ;
  logic errQ;
  ssp_state_type stateQ;
  ssp_state_type stateD;

  logic [1:0] syncPins;
  logic sckSync;
  logic siSync;
  logic setupPh;
  logic wrEn;
  logic [31:0] rdData;
  logic rdHit;
  logic active;
  logic masterMode;
  logic tick;
  logic rise;
  logic fall;
  logic shiftEdge;
  logic doneEv;
  logic dataWr;
  logic busyWr;

  // Pin inputs pass two flops first
  ssp_sync #(
    .WIDTH(2)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .asyncIn({linkIn.shiftClock, linkIn.serialIn}),
    .syncOut(syncPins)
  );
  assign sckSync = syncPins[1];
  assign siSync = syncPins[0];

  // APB decode
  assign setupPh = apbReq.psel & ~apbReq.penable;
  assign wrEn = apbReq.psel & apbReq.penable & apbReq.pwrite;
  assign dataWr = wrEn & (apbReq.paddr == ADDR_DATA);
  assign busyWr = wrEn & (apbReq.paddr == ADDR_BUSY);

  always_comb begin
    rdData = READ_ZERO;
    rdHit = 1'b1;
    if (apbReq.paddr == ADDR_CONTROL) begin
      rdData[CTRL_SELECT_BIT] = selectQ;
      rdData[CTRL_RATE_LOW_BIT] = rateQ[0];
      rdData[CTRL_RATE_HIGH_BIT] = rateQ[1];
    end else if (apbReq.paddr == ADDR_PORTCFG) begin
      rdData[CFG_OUT_BIT] = outCfgQ;
      rdData[CFG_CLK_BIT] = clkCfgQ;
      rdData[CFG_PHASE_BIT] = phaseQ;
    end else if (apbReq.paddr == ADDR_BUSY) begin
      rdData[BUSY_BIT] = busyQ;
    end else if (apbReq.paddr == ADDR_DATA) begin
      rdData[DATA_W-1:0] = shiftQ;
    end else if (apbReq.paddr == ADDR_STATUS) begin
      rdData[DONE_BIT] = statusQ;
    end else if (apbReq.paddr == ADDR_MASK) begin
      rdData[DONE_BIT] = maskQ;
    end else begin
      rdHit = 1'b0;
    end
  end

  // Read data and error captured in setup phase
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdataQ <= READ_ZERO;
      errQ <= 1'b0;
    end else if (setupPh) begin
      prdataQ <= apbReq.pwrite ? READ_ZERO : rdData;
      errQ <= ~rdHit;
    end
  end

  assign prdata = prdataQ;
  assign pready = 1'b1;
  assign pslverr = apbReq.psel & apbReq.penable & errQ;

  // Control and configuration registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      selectQ <= 1'b0;
      rateQ <= RATE_RESET;
    end else if (wrEn && apbReq.paddr == ADDR_CONTROL) begin
      selectQ <= apbReq.pwdata[CTRL_SELECT_BIT];
      rateQ <= {apbReq.pwdata[CTRL_RATE_HIGH_BIT], apbReq.pwdata[CTRL_RATE_LOW_BIT]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      outCfgQ <= 1'b0;
      clkCfgQ <= 1'b0;
      phaseQ <= 1'b0;
    end else if (wrEn && apbReq.paddr == ADDR_PORTCFG) begin
      outCfgQ <= apbReq.pwdata[CFG_OUT_BIT];
      clkCfgQ <= apbReq.pwdata[CFG_CLK_BIT];
      phaseQ <= apbReq.pwdata[CFG_PHASE_BIT];
    end
  end

  // Engine state
  assign masterMode = clkCfgQ;
  assign active = busyQ & selectQ;

  always_comb begin
    stateD = stateQ;
    case (stateQ)
      SH_IDLE: begin
        if (active) begin
          stateD = SH_ACTIVE;
        end
      end
      SH_ACTIVE: begin
        if (!active) begin
          stateD = SH_IDLE;
        end
      end
      default: begin
        stateD = SH_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stateQ <= SH_IDLE;
    end else begin
      stateQ <= stateD;
    end
  end

  // Master clock divider
  assign tick = masterMode & (stateQ == SH_ACTIVE) & active & (divCntQ == sspHalfPeriod(rateQ) - DIV_ONE);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      divCntQ <= DIV_ZERO;
      sckQ <= 1'b0;
    end else if (!active || !masterMode || stateQ != SH_ACTIVE) begin
      divCntQ <= DIV_ZERO;
      sckQ <= 1'b0;
    end else if (tick) begin
      divCntQ <= DIV_ZERO;
      sckQ <= ~sckQ;
    end else begin
      divCntQ <= divCntQ + DIV_ONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sckPrevQ <= 1'b0;
    end else begin
      sckPrevQ <= sckSync;
    end
  end

  // Edges from own divider or synchronised pin
  always_comb begin
    if (masterMode) begin
      rise = tick & ~sckQ;
      fall = tick & sckQ;
    end else begin
      rise = (stateQ == SH_ACTIVE) & active & sckSync & ~sckPrevQ;
      fall = (stateQ == SH_ACTIVE) & active & ~sckSync & sckPrevQ;
    end
  end

  assign shiftEdge = phaseQ ? rise : fall;
  assign doneEv = fall & (bitCntQ == LAST_BIT);

  // Input sample on rising edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sampleQ <= 1'b0;
    end else if (rise) begin
      sampleQ <= siSync;
    end
  end

  // Shift register; software load wins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shiftQ <= DATA_RESET;
    end else if (dataWr) begin
      shiftQ <= apbReq.pwdata[DATA_W-1:0];
    end else if (shiftEdge) begin
      shiftQ <= {shiftQ[DATA_W-2:0], phaseQ ? siSync : sampleQ};
    end
  end

  // Pulse counter, one per falling edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bitCntQ <= CNT_ZERO;
    end else if (stateQ != SH_ACTIVE) begin
      bitCntQ <= CNT_ZERO;
    end else if (fall) begin
      bitCntQ <= bitCntQ + CNT_ONE;
    end
  end

  // Busy flag
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busyQ <= 1'b0;
    end else if (!selectQ) begin
      busyQ <= 1'b0;
    end else if (doneEv) begin
      busyQ <= 1'b0;
    end else if (busyWr) begin
      busyQ <= apbReq.pwdata[BUSY_BIT];
    end
  end

  // Sticky completion status, write one to clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      statusQ <= 1'b0;
    end else if (doneEv) begin
      statusQ <= 1'b1;
    end else if (wrEn && apbReq.paddr == ADDR_STATUS && apbReq.pwdata[DONE_BIT]) begin
      statusQ <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      maskQ <= 1'b0;
    end else if (wrEn && apbReq.paddr == ADDR_MASK) begin
      maskQ <= apbReq.pwdata[DONE_BIT];
    end
  end

  assign irq = statusQ & maskQ;

  // Pins
  assign linkOut.shiftClock = sckQ;
  assign linkOut.shiftClockOe = selectQ & clkCfgQ;
  assign linkOut.serialOut = shiftQ[DATA_W-1];
  assign linkOut.serialOutOe = selectQ & outCfgQ;

  // Checks
  sequence swStop;
    busyWr && !apbReq.pwdata[BUSY_BIT] && active;
  endsequence

  sequence clockHeldLow;
    (!sckQ) [*3];
  endsequence

  AST_SELECT_GATES: assert property (@(posedge ref_clk) disable iff (reset)
    !selectQ |=> !busyQ)
    else $error("busy set while port not selected");

  AST_HALF_PERIOD: assert property (@(posedge ref_clk) disable iff (reset)
    ($changed(sckQ) && $past(active) && $past(masterMode) && $past(stateQ == SH_ACTIVE))
      |-> $past(divCntQ) == sspHalfPeriod($past(rateQ)) - DIV_ONE)
    else $error("generated clock toggled at wrong count");

  AST_DONE_CLEARS: assert property (@(posedge ref_clk) disable iff (reset)
    doneEv |-> bitCntQ == LAST_BIT ##1 (!busyQ && statusQ))
    else $error("completion did not clear busy and set status");

  AST_SW_STOP: assert property (@(posedge ref_clk) disable iff (reset)
    swStop |=> !busyQ ##1 clockHeldLow)
    else $error("clearing busy did not stop the clock");

  AST_IRQ_ON_DONE: assert property (@(posedge ref_clk) disable iff (reset)
    (doneEv && maskQ) |=> irq)
    else $error("enabled completion gave no interrupt");

  AST_IDLE_LOW: assert property (@(posedge ref_clk) disable iff (reset)
    !active |=> !sckQ)
    else $error("shift clock high while idle");

  AST_SLAVE_NO_CLOCK: assert property (@(posedge ref_clk) disable iff (reset)
    !clkCfgQ |-> (!linkOut.shiftClockOe && !sckQ))
    else $error("slave mode drives shift clock");

  AST_NORMAL_SHIFT: assert property (@(posedge ref_clk) disable iff (reset)
    (fall && !phaseQ && !dataWr) |=> shiftQ == {$past(shiftQ[DATA_W-2:0]), $past(sampleQ)})
    else $error("normal phase shift wrong");

  AST_ALT_SHIFT: assert property (@(posedge ref_clk) disable iff (reset)
    (rise && phaseQ && !dataWr) |=> shiftQ == {$past(shiftQ[DATA_W-2:0]), $past(siSync)})
    else $error("alternate phase shift wrong");

  AST_PHASE_RESET: assert property (@(posedge ref_clk)
    $past(reset) |-> !phaseQ)
    else $error("phase select not cleared by reset");
endmodule

// File: dv/ssp_far_end.sv
// Far-end peripheral model for the serial shift port
`timescale 1ns/1ns
module ssp_far_end (
  input wire logic pinClk,  // Shift clock pin level
  input wire logic pinData,  // Data from the port
  output logic clkOut,  // Clock when the model is master
  output logic dataOut  // Data to the port
);
  logic [7:0] txQ;
  logic [7:0] rxQ;

  initial begin
    clkOut = 1'b0;
    txQ = 8'h00;
    rxQ = 8'h00;
  end

  assign dataOut = txQ[7];

  // Sample on rise, shift out on fall; refill with a toggling pattern
  always @(posedge pinClk) begin
    rxQ <= {rxQ[6:0], pinData};
  end
  always @(negedge pinClk) begin
    txQ <= {txQ[6:0], ~txQ[7]};
  end

  // Eight pulses, clock left low between frames
  task automatic frame();
    #1;
    repeat (8) begin
      #80 clkOut = 1'b1;
      #80 clkOut = 1'b0;
    end
  endtask
endmodule

// File: dv/ssp_shift_port_tb.sv
// Self-checking bench for the serial shift port
`timescale 1ns/1ns
module ssp_shift_port_tb;
  import ssp_pkg::*;
  logic ref_clk;
  logic reset;
  ssp_apb_req_type req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ssp_link_in_type linkIn;
  ssp_link_out_type linkOut;
  logic irq;
  logic farClk;
  logic farData;
  logic pinClk;
  logic [31:0] rd;
  logic err;
  int failCount = 0;
  int checked = 0;
  int cyc = 0;

  // Clock pin level from whichever side drives it
  assign pinClk = linkOut.shiftClockOe ? linkOut.shiftClock : farClk;
  assign linkIn = {pinClk, farData};

  ssp_shift_port DUT (.ref_clk(ref_clk), .reset(reset), .apbReq(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .linkIn(linkIn), .linkOut(linkOut), .irq(irq));
  ssp_far_end far (.pinClk(pinClk), .pinData(linkOut.serialOut), .clkOut(farClk), .dataOut(farData));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failCount++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, READ_ZERO);
    chk(rd, exp, msg);
  endtask

  task automatic countFalls(input int n, output int hi);
    int falls;
    logic prev;
    falls = 0;
    prev = 1'b0;
    hi = 0;
    for (int i = 0; i < 1000 && falls < n; i++) begin
      @(posedge ref_clk);
      hi += int'(linkOut.shiftClock);
      falls += int'(prev & ~linkOut.shiftClock);
      prev = linkOut.shiftClock;
    end
  endtask

  task automatic master(input logic [1:0] rate, input logic [31:0] cfg, input logic [7:0] tx,
    input logic [7:0] fx, input logic msk);
    apb(1'b1, ADDR_CONTROL, {29'h0, rate, 1'b1});
    apb(1'b1, ADDR_PORTCFG, cfg);
    apb(1'b1, ADDR_DATA, {24'h0, tx});
    apb(1'b1, ADDR_MASK, {31'h0, msk});
    far.txQ = fx;
    apb(1'b1, ADDR_BUSY, 32'h0000_0001);
  endtask

  task automatic resetVals();
    rdChk(ADDR_CONTROL, READ_ZERO, "control reset");
    rdChk(ADDR_PORTCFG, READ_ZERO, "phase reset");
    rdChk(ADDR_BUSY, READ_ZERO, "busy reset");
    apb(1'b0, 8'h18, READ_ZERO);
    chk({31'h0, err}, 32'h0000_0001, "unmapped");
    chk({27'h0, irq, linkOut}, READ_ZERO, "pins reset");
  endtask

  task automatic xfer(input logic [1:0] rate, input int half);
    int hi;
    master(rate, 32'h0000_0030, 8'hA6, 8'h3C, rate != 2'h1);
    countFalls(8, hi);
    chk(32'(hi), 32'(8 * half), "high time");
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irq}, {31'h0, rate != 2'h1}, "irq");
    chk({24'h0, far.rxQ}, 32'h0000_00A6, "far rx");
    rdChk(ADDR_DATA, 32'h0000_003C, "data in");
    rdChk(ADDR_BUSY, READ_ZERO, "busy end");
    rdChk(ADDR_STATUS, 32'h0000_0001, "done");
    apb(1'b1, ADDR_STATUS, 32'h0000_0001);
    @(negedge ref_clk);
    chk({30'h0, irq, linkOut.shiftClock}, READ_ZERO, "irq clear idle");
  endtask

  task automatic abort();
    int hi;
    master(2'h0, 32'h0000_0030, 8'h81, 8'h00, 1'b1);
    countFalls(3, hi);
    apb(1'b1, ADDR_BUSY, READ_ZERO);
    @(posedge ref_clk);
    countFalls(1, hi);
    chk(32'(hi), READ_ZERO, "clock after stop");
    rdChk(ADDR_DATA, 32'h0000_0008, "partial shift");
    rdChk(ADDR_STATUS, READ_ZERO, "no done");
    chk({31'h0, irq}, READ_ZERO, "no irq");
  endtask

  task automatic selOff();
    apb(1'b1, ADDR_CONTROL, READ_ZERO);
    apb(1'b1, ADDR_BUSY, 32'h0000_0001);
    rdChk(ADDR_BUSY, READ_ZERO, "busy unselected");
    chk({30'h0, linkOut.shiftClockOe, linkOut.serialOutOe}, READ_ZERO, "pins off");
  endtask

  task automatic phase();
    int hi;
    master(2'h0, 32'h0000_0070, 8'hA5, 8'h96, 1'b0);
    rdChk(ADDR_PORTCFG, 32'h0000_0070, "alt cfg");
    countFalls(8, hi);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, linkOut.shiftClock}, READ_ZERO, "alt idle");
    rdChk(ADDR_STATUS, 32'h0000_0001, "alt done");
    rdChk(ADDR_DATA, 32'h0000_0096, "alt data in");
  endtask

  task automatic slave();
    apb(1'b1, ADDR_CONTROL, 32'h0000_0001);
    apb(1'b1, ADDR_PORTCFG, 32'h0000_0010);
    @(negedge ref_clk);
    chk({30'h0, linkOut.shiftClockOe, linkOut.serialOutOe}, 32'h0000_0001, "slave pins");
    apb(1'b1, ADDR_DATA, 32'h0000_005A);
    far.txQ = 8'hC3;
    apb(1'b1, ADDR_BUSY, 32'h0000_0001);
    far.frame();
    repeat (6) @(posedge ref_clk);
    chk({24'h0, far.rxQ}, 32'h0000_005A, "slave out");
    rdChk(ADDR_DATA, 32'h0000_00C3, "slave in");
    rdChk(ADDR_BUSY, READ_ZERO, "slave busy end");
  endtask

  initial begin
    reset = 1'b1;
    req = '0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    resetVals();
    for (int r = 0; r < 4; r++) begin
      xfer(2'(r), TC_CYCLES << (r > 1 ? 2 : r));
    end
    abort();
    selOff();
    phase();
    slave();
    results();
  end
endmodule
